// *** hw/light_regs_pkg.sv ***
// Purpose: Shared constants for the light sensor result and setup registers.
// Assumes: 16-bit registers reached by pointer, bytes moved MSB first.
// Notes: Field positions refer to the sensor_setup register, except the EXP and MANT ones, which refer to the result register.
package light_regs_pkg;
  localparam int REG_W = 16;
  localparam logic [7:0] RESULT_OFFSET = 8'h00;
  localparam logic [7:0] SETUP_OFFSET = 8'h01;
  localparam logic [15:0] SETUP_RESET = 16'hC810;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  // Bits software may change; status bits 8..5 excluded
  localparam logic [15:0] SETUP_WRITE_MASK = 16'hFE1F;
  localparam int RANGE_MSB = 15;
  localparam int RANGE_LSB = 12;
  localparam int CONV_TIME_BIT = 11;
  localparam int MODE_MSB = 10;
  localparam int MODE_LSB = 9;
  localparam int OVERFLOW_BIT = 8;
  localparam int READY_BIT = 7;
  localparam int HIGH_HIT_BIT = 6;
  localparam int LOW_HIT_BIT = 5;
  localparam int LATCH_BIT = 4;
  localparam int POLARITY_BIT = 3;
  localparam int EXP_MASK_BIT = 2;
  localparam int FAULT_MSB = 1;
  localparam int FAULT_LSB = 0;
  localparam int EXP_MSB = 15;
  localparam int EXP_LSB = 12;
  localparam int MANT_MSB = 11;
  localparam logic [3:0] RANGE_AUTO = 4'hC;
  localparam logic [3:0] EXP_ZERO = 4'h0;
  localparam logic [1:0] MODE_SHUTDOWN = 2'h0;
  localparam logic [1:0] MODE_SINGLE = 2'h1;
endpackage

// *** hw/light_result_and_config_regs.sv ***
// Purpose: Result and setup registers of an ambient light sensor, byte port side.
// Assumes: A serial-bus engine on ref_clk_in supplies pointer and byte strobes.
// Notes: Conversion core is outside; this block starts, aborts and records it.
`timescale 1ns/1ps

module light_result_and_config_regs
  import light_regs_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic xfer_start_in,
  input wire logic pointer_we_in,
  input wire logic [7:0] pointer_in,
  input wire logic wr_byte_valid_in,
  input wire logic [7:0] wr_byte_in,
  input wire logic rd_byte_req_in,
  output logic [7:0] rd_byte_out,
  output logic rd_byte_valid_out,
  input wire logic conv_done_in,
  input wire logic [3:0] conv_exponent_in,
  input wire logic [11:0] conv_mantissa_in,
  input wire logic conv_overflow_in,
  input wire logic high_limit_event_in,
  input wire logic low_limit_event_in,
  output logic conv_start_out,
  output logic conv_abort_out,
  output logic conv_busy_out,
  output logic [3:0] range_select_out,
  output logic conversion_time_sel_out,
  output logic conversion_mode_upper_out,
  output logic conversion_mode_lower_out,
  output logic latch_mode_out,
  output logic int_active_level_out,
  output logic fault_count_upper_out,
  output logic fault_count_lower_out
);

  logic [7:0] pointer_reg;
  logic [15:0] setup_reg;
  logic [15:0] result_reg;
  logic [15:0] rd_snapshot_reg;
  logic [7:0] wr_msb_reg;
  logic wr_phase_reg;
  logic rd_phase_reg;
  logic busy_reg;
  logic start_reg;
  logic abort_reg;
  logic [7:0] rd_byte_reg;
  logic rd_valid_reg;

  logic setup_commit;
  logic [15:0] setup_wdata;
  logic setup_read_first;
  logic [15:0] setup_next;
  logic [1:0] mode_next;
  logic done_ok;
  logic [3:0] exp_next;
  logic [15:0] rd_word;
  logic byte_phase_clear;

  function automatic logic [15:0] read_mux(input logic [7:0] ptr, input logic [15:0] res,
                                           input logic [15:0] setup);
    if (ptr == RESULT_OFFSET) begin
      read_mux = res;
    end else if (ptr == SETUP_OFFSET) begin
      read_mux = setup;
    end else begin
      read_mux = 16'h0000;
    end
  endfunction

  // Second byte of a write carries the LSB
  assign setup_wdata = {wr_msb_reg, wr_byte_in};
  // Only the setup register accepts data; result writes fall through
  // Phase reset has priority, so a byte racing it never commits or clears flags
  assign byte_phase_clear = xfer_start_in || pointer_we_in;
  assign setup_commit = wr_byte_valid_in && wr_phase_reg && !byte_phase_clear &&
                        (pointer_reg == SETUP_OFFSET);
  assign setup_read_first = rd_byte_req_in && !rd_phase_reg && !byte_phase_clear &&
                            (pointer_reg == SETUP_OFFSET);
  assign rd_word = read_mux(pointer_reg, result_reg, setup_reg);
  assign mode_next = setup_wdata[MODE_MSB:MODE_LSB];
  // A completion racing an abort is discarded
  assign done_ok = conv_done_in && busy_reg && !setup_commit;

  always_comb begin
    exp_next = conv_exponent_in;
    if (setup_reg[EXP_MASK_BIT] && (setup_reg[RANGE_MSB:RANGE_LSB] < RANGE_AUTO)) begin
      exp_next = EXP_ZERO;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      pointer_reg <= RESULT_OFFSET;
    end else if (pointer_we_in) begin
      pointer_reg <= pointer_in;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      wr_phase_reg <= 1'b0;
      wr_msb_reg <= 8'h00;
    end else if (xfer_start_in || pointer_we_in) begin
      wr_phase_reg <= 1'b0;
    end else if (wr_byte_valid_in) begin
      wr_phase_reg <= !wr_phase_reg;
      if (!wr_phase_reg) begin
        wr_msb_reg <= wr_byte_in;
      end
    end
  end

  // Status flags: hardware set wins over the clear from a setup read
  always_comb begin
    setup_next = setup_reg;
    if (setup_commit) begin
      setup_next = (setup_reg & ~SETUP_WRITE_MASK) |
                   (setup_wdata & SETUP_WRITE_MASK);
    end
    if (setup_read_first) begin
      setup_next[READY_BIT] = 1'b0;
      setup_next[HIGH_HIT_BIT] = 1'b0;
      setup_next[LOW_HIT_BIT] = 1'b0;
    end
    if (done_ok) begin
      setup_next[READY_BIT] = 1'b1;
      setup_next[OVERFLOW_BIT] = conv_overflow_in;
      if (setup_reg[MODE_MSB:MODE_LSB] == MODE_SINGLE) begin
        setup_next[MODE_MSB:MODE_LSB] = MODE_SHUTDOWN;
      end
    end
    if (high_limit_event_in) begin
      setup_next[HIGH_HIT_BIT] = 1'b1;
    end
    if (low_limit_event_in) begin
      setup_next[LOW_HIT_BIT] = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      setup_reg <= SETUP_RESET;
    end else begin
      setup_reg <= setup_next;
    end
  end

  // Mantissa kept raw; lux = 0.01 * 2^exp * mantissa is decoded by the host
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      result_reg <= RESULT_RESET;
    end else if (done_ok) begin
      result_reg <= {exp_next, conv_mantissa_in};
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      busy_reg <= 1'b0;
      start_reg <= 1'b0;
      abort_reg <= 1'b0;
    end else if (setup_commit) begin
      abort_reg <= busy_reg;
      start_reg <= (mode_next != MODE_SHUTDOWN);
      busy_reg <= (mode_next != MODE_SHUTDOWN);
    end else begin
      abort_reg <= 1'b0;
      // Continuous mode chains the next conversion itself
      start_reg <= done_ok && (setup_reg[MODE_MSB] == 1'b1);
      if (done_ok) begin
        busy_reg <= (setup_reg[MODE_MSB] == 1'b1);
      end
    end
  end

  // Snapshot at MSB so the LSB belongs to the same value
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      rd_phase_reg <= 1'b0;
      rd_snapshot_reg <= 16'h0000;
      rd_byte_reg <= 8'h00;
      rd_valid_reg <= 1'b0;
    end else begin
      rd_valid_reg <= rd_byte_req_in;
      if (xfer_start_in || pointer_we_in) begin
        rd_phase_reg <= 1'b0;
      end else if (rd_byte_req_in) begin
        rd_phase_reg <= !rd_phase_reg;
        if (!rd_phase_reg) begin
          rd_snapshot_reg <= rd_word;
          rd_byte_reg <= rd_word[15:8];
        end else begin
          rd_byte_reg <= rd_snapshot_reg[7:0];
        end
      end
    end
  end

  assign rd_byte_out = rd_byte_reg;
  assign rd_byte_valid_out = rd_valid_reg;
  assign conv_start_out = start_reg;
  assign conv_abort_out = abort_reg;
  assign conv_busy_out = busy_reg;
  assign range_select_out = setup_reg[RANGE_MSB:RANGE_LSB];
  assign conversion_time_sel_out = setup_reg[CONV_TIME_BIT];
  assign conversion_mode_upper_out = setup_reg[MODE_MSB];
  assign conversion_mode_lower_out = setup_reg[MODE_LSB];
  assign latch_mode_out = setup_reg[LATCH_BIT];
  assign int_active_level_out = setup_reg[POLARITY_BIT];
  assign fault_count_upper_out = setup_reg[FAULT_MSB];
  assign fault_count_lower_out = setup_reg[FAULT_LSB];

endmodule

// *** verification/light_regs_sva.sv ***
// Purpose: Port checks for the light register block.
// Assumes: One clock, sync reset.
// Notes: Bound to the design top.
`timescale 1ns/1ps
module light_regs_sva (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic rd_byte_req_in,
  input wire logic wr_byte_valid_in,
  input wire logic conv_done_in,
  input wire logic rd_byte_valid_out,
  input wire logic conv_start_out,
  input wire logic conv_abort_out,
  input wire logic conv_busy_out,
  input wire logic [3:0] range_select_out,
  input wire logic conversion_time_sel_out,
  input wire logic conversion_mode_upper_out,
  input wire logic conversion_mode_lower_out,
  input wire logic latch_mode_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  sequence s_single_done;
    conv_busy_out && conv_done_in && !wr_byte_valid_in && !conversion_mode_upper_out &&
      conversion_mode_lower_out;
  endsequence
  sequence s_mode_on;
    conversion_mode_upper_out || conversion_mode_lower_out;
  endsequence
  sequence s_no_write;
    !wr_byte_valid_in && !conv_done_in;
  endsequence
  sequence s_reset_state;
    range_select_out == 4'hC && conversion_time_sel_out && latch_mode_out && !conv_busy_out &&
      !conv_start_out && !conv_abort_out && !rd_byte_valid_out && !conversion_mode_upper_out &&
      !conversion_mode_lower_out;
  endsequence
  a_read_answer: assert property (rd_byte_req_in |=> rd_byte_valid_out)
    else $error("read byte not answered");
  a_valid_cause: assert property (rd_byte_valid_out |-> $past(rd_byte_req_in))
    else $error("read byte without request");
  a_abort_busy: assert property (conv_abort_out |-> $past(conv_busy_out))
    else $error("abort while idle");
  a_start_busy: assert property (conv_start_out |-> conv_busy_out)
    else $error("start without busy");
  a_start_mode: assert property (conv_start_out |-> s_mode_on)
    else $error("start in shutdown");
  a_single_ends: assert property (s_single_done |=> !conversion_mode_lower_out)
    else $error("single shot mode kept");
  a_setup_hold: assert property (s_no_write |=> $stable(range_select_out))
    else $error("range moved without write");
  a_reset_value: assert property (disable iff (1'b0) rst_in |=> s_reset_state)
    else $error("bad reset state");
endmodule
bind light_result_and_config_regs light_regs_sva i_chk (.*);

// *** verification/light_host_model.sv ***
// Purpose: Byte-level host that reads and writes the registers.
// Assumes: Strobes change at falling edges.
// Notes: Released data lines show inverted values.
`timescale 1ns/1ps
module light_host_model (
  input wire logic clk_in,
  input wire logic [7:0] rd_byte_in,
  input wire logic rd_valid_in,
  output logic pointer_we_out,
  output logic [7:0] pointer_out,
  output logic wr_valid_out,
  output logic [7:0] wr_byte_out,
  output logic rd_req_out
);
  initial {pointer_we_out, pointer_out, wr_valid_out, wr_byte_out, rd_req_out} = '0;
  task automatic wr(input logic [7:0] p, input logic [15:0] v);
    @(negedge clk_in) {pointer_we_out, pointer_out} <= {1'b1, p};
    @(negedge clk_in) {pointer_we_out, wr_valid_out, wr_byte_out} <= {2'b01, v[15:8]};
    @(negedge clk_in) wr_byte_out <= v[7:0];
    @(negedge clk_in) {wr_valid_out, wr_byte_out} <= {1'b0, ~v[7:0]};
  endtask
  // Lone data byte with no pointer phase, for byte pairing tests
  task automatic wr1(input logic [7:0] b);
    @(negedge clk_in) {wr_valid_out, wr_byte_out} <= {1'b1, b};
    @(negedge clk_in) {wr_valid_out, wr_byte_out} <= {1'b0, ~b};
  endtask
  task automatic rd(input logic [7:0] p, output logic [15:0] v);
    @(negedge clk_in) {pointer_we_out, pointer_out} <= {1'b1, p};
    repeat (2) begin
      @(negedge clk_in) {pointer_we_out, rd_req_out} <= 2'b01;
      @(negedge clk_in) rd_req_out <= 1'b0;
      v = {v[7:0], rd_valid_in === 1'b1 ? rd_byte_in : 8'hxx};
    end
  endtask
  // Codes need not be normalised, so compare decoded hundredths of lux
  function automatic logic [31:0] lux(input logic [15:0] v);
    return 32'(v[11:0]) << v[15:12];
  endfunction
endmodule

// *** verification/testbench.sv ***
// Purpose: Directed register and conversion tests.
// Assumes: Conversion engine played by the bench.
// Notes: Limit event inputs stay low except for one cycle where both pulse high together.
`timescale 1ns/1ps
`define CHK(a, e) begin \
  checks_done++; \
  if ((a) !== (e)) begin \
    fails++; \
    $display("[ERR] %0t got %0h want %0h", $time, a, e); \
  end \
end
module testbench;
  import light_regs_pkg::*;
  logic ref_clk_in, rst_in, xfer_start_in, pointer_we_in, wr_byte_valid_in, rd_byte_req_in;
  logic rd_byte_valid_out, conv_done_in, conv_overflow_in, high_limit_event_in, low_limit_event_in;
  logic conv_start_out, conv_abort_out, conv_busy_out, conversion_time_sel_out, latch_mode_out;
  logic conversion_mode_upper_out, conversion_mode_lower_out, int_active_level_out;
  logic fault_count_upper_out, fault_count_lower_out;
  logic [7:0] pointer_in, wr_byte_in, rd_byte_out;
  logic [3:0] conv_exponent_in, range_select_out;
  logic [11:0] conv_mantissa_in;
  logic [15:0] v;
  int fails = 0;
  int checks_done = 0;
  light_result_and_config_regs i_light_result_and_config_regs (.*);
  light_host_model i_host (.clk_in(ref_clk_in), .rd_byte_in(rd_byte_out),
    .rd_valid_in(rd_byte_valid_out), .pointer_we_out(pointer_we_in), .pointer_out(pointer_in),
    .wr_valid_out(wr_byte_valid_in), .wr_byte_out(wr_byte_in), .rd_req_out(rd_byte_req_in));
  initial begin
    ref_clk_in = 1'b0;
    forever #4 ref_clk_in = ~ref_clk_in;
  end
  task automatic test_done();
    if (fails == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic convert(input logic [3:0] e, input logic [11:0] m, input logic o);
    @(negedge ref_clk_in) {conv_done_in, conv_exponent_in, conv_mantissa_in, conv_overflow_in} <=
      {1'b1, e, m, o};
    @(negedge ref_clk_in) conv_done_in <= 1'b0;
  endtask
  initial begin
    {rst_in, xfer_start_in, high_limit_event_in, low_limit_event_in} = 4'b1000;
    {conv_done_in, conv_exponent_in, conv_mantissa_in, conv_overflow_in} = '0;
    repeat (8) @(negedge ref_clk_in);
    rst_in = 1'b0;
    i_host.rd(SETUP_OFFSET, v);
    `CHK(v, 16'hC810)
    i_host.rd(RESULT_OFFSET, v);
    `CHK(v, 16'h0000)
    i_host.wr(SETUP_OFFSET, 16'hFFFF);
    `CHK(conv_start_out, 1'b1)
    i_host.rd(SETUP_OFFSET, v);
    `CHK(v, 16'hFE1F)
    i_host.wr(SETUP_OFFSET, 16'h3204);
    `CHK({conv_abort_out, conv_start_out}, 2'b11)
    convert(4'h5, 12'h456, 1'b0);
    i_host.rd(RESULT_OFFSET, v);
    `CHK(v, 16'h0456)
    i_host.rd(SETUP_OFFSET, v);
    `CHK(v, 16'h3084)
    i_host.wr(RESULT_OFFSET, 16'hFFFF);
    i_host.rd(RESULT_OFFSET, v);
    `CHK(v, 16'h0456)
    i_host.wr(SETUP_OFFSET, 16'hC400);
    `CHK({conv_abort_out, conv_start_out}, 2'b01)
    convert(4'hB, 12'hFFF, 1'b1);
    i_host.rd(RESULT_OFFSET, v);
    `CHK(v, 16'hBFFF)
    `CHK(i_host.lux(v), 32'h007FF800)
    i_host.rd(SETUP_OFFSET, v);
    `CHK(v, 16'hC580)
    i_host.wr(SETUP_OFFSET, 16'h0000);
    `CHK({conv_abort_out, conv_start_out}, 2'b10)
    // Odd byte dropped by a new transfer, then a clean pair lands
    i_host.wr1(8'h00);
    @(negedge ref_clk_in) xfer_start_in <= 1'b1;
    @(negedge ref_clk_in) xfer_start_in <= 1'b0;
    i_host.wr1(8'h18);
    i_host.wr1(8'h0A);
    `CHK(range_select_out, 4'h1)
    `CHK({conversion_mode_upper_out, conversion_mode_lower_out}, 2'h0)
    `CHK({fault_count_upper_out, fault_count_lower_out}, 2'h2)
    `CHK({conversion_time_sel_out, latch_mode_out, int_active_level_out}, 3'h5)
    @(negedge ref_clk_in) {high_limit_event_in, low_limit_event_in} <= 2'b11;
    @(negedge ref_clk_in) {high_limit_event_in, low_limit_event_in} <= 2'b00;
    i_host.rd(SETUP_OFFSET, v);
    `CHK(v, 16'h196A)
    i_host.rd(SETUP_OFFSET, v);
    `CHK(v, 16'h190A)
    test_done();
  end
endmodule
